// file: rla_pkg.sv
// Package with register map, field layout, types for the lookup RAM access port
package rla_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [15:0] RLA_IDX_ADDR   = 16'h2887;
  localparam logic [15:0] RLA_IDX_DATA   = 16'h2888;
  localparam logic [15:0] RLA_IDX_STROBE = 16'h2889;
  localparam logic [15:0] RLA_BA_ADDR    = 16'(RLA_IDX_ADDR * 4);
  localparam logic [15:0] RLA_BA_DATA    = 16'(RLA_IDX_DATA * 4);
  localparam logic [15:0] RLA_BA_STROBE  = 16'(RLA_IDX_STROBE * 4);

  // Field positions
  localparam int RLA_AUTO_BIT = 7;
  localparam int RLA_RD_BIT   = 1;
  localparam int RLA_WR_BIT   = 0;

  // Widths and reset values
  localparam int          RLA_AW         = 7;
  localparam int          RLA_DW         = 8;
  localparam int          RLA_DEPTH      = 128;
  localparam logic [6:0]  RLA_ADDR_RST   = 7'h00;
  localparam logic [7:0]  RLA_DATA_RST   = 8'h00;
  localparam logic [1:0]  RLA_STROBE_RST = 2'h0;
  localparam logic [31:0] RLA_RDATA_RST  = 32'h0000_0000;

  // Register decode result
  typedef enum logic [1:0] {
    RLA_SEL_NONE,
    RLA_SEL_ADDR,
    RLA_SEL_DATA,
    RLA_SEL_STROBE
  } rla_sel_t;

  // Access sequencer states
  typedef enum logic [1:0] {
    RLA_IDLE,
    RLA_RUN,
    RLA_FINISH
  } rla_state_t;

  // One request to the lookup RAM
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rla_ram_req_t;

endpackage : rla_pkg

// file: rla_lookup_ram.sv
// Lookup RAM of 128 bytes with registered read data
`timescale 1ns/1ps
module rla_lookup_ram
  import rla_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Request
  input  wire rla_ram_req_t req,
  // Answer, valid the cycle after a read request
  output logic [7:0]        rdata_q
);

  logic [7:0] mem [RLA_DEPTH];
  logic [7:0] rdata_d;

  ////////////////////////////////////////////////////////////////////////
  // Read port; old content is kept when no read is asked for
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      rdata_d = mem[req.addr];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= RLA_DATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage has no reset; software is expected to load it before use
  always_ff @(posedge clk) begin
    if (req.wr) begin
      mem[req.addr] <= req.wdata;
    end
  end

endmodule : rla_lookup_ram

// file: rla_access.sv
// APB register bank giving indirect access to the lookup RAM
`timescale 1ns/1ps
// Functional notes
// - Seven-bit address selects lookup RAM location
// - Eight-bit data register holds written/read byte
// - Setting read or write strobe starts access
// - Strobe stays set, clears itself when done
// - Auto-step adds one to address on completion
// - Address register reads back the stepped value
module rla_access
  import rla_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode, used for both the read path and the write path
  function automatic rla_sel_t rla_decode(input logic [15:0] a);
    rla_sel_t s;
    s = RLA_SEL_NONE;
    unique case (a)
      RLA_BA_ADDR:   s = RLA_SEL_ADDR;
      RLA_BA_DATA:   s = RLA_SEL_DATA;
      RLA_BA_STROBE: s = RLA_SEL_STROBE;
      default:       s = RLA_SEL_NONE;
    endcase
    return s;
  endfunction : rla_decode

  logic         lookup_auto_step_q;
  logic         lookup_auto_step_d;
  logic [6:0]   lookup_address_q;
  logic [6:0]   lookup_address_d;
  logic [7:0]   lookup_data_value_q;
  logic [7:0]   lookup_data_value_d;
  logic         lookup_read_strobe_q;
  logic         lookup_read_strobe_d;
  logic         lookup_write_strobe_q;
  logic         lookup_write_strobe_d;
  rla_state_t   state_q;
  rla_state_t   state_d;
  logic         op_wr_q;
  logic         op_wr_d;
  rla_ram_req_t ram_req;
  logic [7:0]   ram_rdata;
  logic         pready_d;
  logic [31:0]  prdata_d;
  logic         pslverr_d;
  rla_sel_t     sel;
  logic         setup;
  logic         wr_acc;
  logic         busy;
  logic         done;

  assign sel    = rla_decode(PADDR);
  assign setup  = PSEL && !PENABLE;
  // Zero-wait slave: the access phase always ends at its first edge
  assign wr_acc = PSEL && PENABLE && PWRITE && PSTRB[0];
  assign busy   = (state_q != RLA_IDLE);
  assign done   = (state_q == RLA_FINISH);

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer: IDLE picks a strobe, RUN drives the RAM, FINISH retires
  always_comb begin
    state_d = state_q;
    op_wr_d = op_wr_q;
    ram_req = '0;
    unique case (state_q)
      RLA_IDLE: begin
        // Write strobe wins when software sets both together
        if (lookup_write_strobe_q || lookup_read_strobe_q) begin
          op_wr_d = lookup_write_strobe_q;
          state_d = RLA_RUN;
        end
      end
      RLA_RUN: begin
        ram_req.wr    = op_wr_q;
        ram_req.rd    = !op_wr_q;
        ram_req.addr  = lookup_address_q;
        ram_req.wdata = lookup_data_value_q;
        state_d       = RLA_FINISH;
      end
      RLA_FINISH: begin
        state_d = RLA_IDLE;
      end
      // The fourth code is never entered; fall back to idle if it ever is
      default: begin
        state_d = RLA_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= RLA_IDLE;
      op_wr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_wr_q <= op_wr_d;
    end
  end

  rla_lookup_ram u_ram (
    .clk     (CLK),
    .rst_b   (RST_B),
    .req     (ram_req),
    .rdata_q (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register state. Address and data are frozen while an access runs, so the
  // RAM sees the values held when the sequencer left IDLE; a read queued behind a write uses the stepped address.
  always_comb begin
    lookup_auto_step_d    = lookup_auto_step_q;
    lookup_address_d      = lookup_address_q;
    lookup_data_value_d   = lookup_data_value_q;
    lookup_read_strobe_d  = lookup_read_strobe_q;
    lookup_write_strobe_d = lookup_write_strobe_q;
    // Completion: clear the strobe, step the address, capture read data
    if (done) begin
      if (op_wr_q) begin
        lookup_write_strobe_d = 1'b0;
      end else begin
        lookup_read_strobe_d = 1'b0;
        lookup_data_value_d  = ram_rdata;
      end
      if (lookup_auto_step_q) begin
        lookup_address_d = lookup_address_q + 7'h01;
      end
    end
    // Software writes; a set of a strobe wins over its own clear
    if (wr_acc) begin
      unique case (sel)
        RLA_SEL_ADDR: begin
          if (!busy) begin
            lookup_auto_step_d = PWDATA[RLA_AUTO_BIT];
            lookup_address_d   = PWDATA[RLA_AW-1:0];
          end
        end
        RLA_SEL_DATA: begin
          if (!busy) begin
            lookup_data_value_d = PWDATA[RLA_DW-1:0];
          end
        end
        RLA_SEL_STROBE: begin
          // Writing zero cannot abort an access in flight
          if (PWDATA[RLA_RD_BIT]) begin
            lookup_read_strobe_d = 1'b1;
          end
          if (PWDATA[RLA_WR_BIT]) begin
            lookup_write_strobe_d = 1'b1;
          end
        end
        RLA_SEL_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lookup_auto_step_q    <= 1'b0;
      lookup_address_q      <= RLA_ADDR_RST;
      lookup_data_value_q   <= RLA_DATA_RST;
      lookup_read_strobe_q  <= RLA_STROBE_RST[RLA_RD_BIT];
      lookup_write_strobe_q <= RLA_STROBE_RST[RLA_WR_BIT];
    end else begin
      lookup_auto_step_q    <= lookup_auto_step_d;
      lookup_address_q      <= lookup_address_d;
      lookup_data_value_q   <= lookup_data_value_d;
      lookup_read_strobe_q  <= lookup_read_strobe_d;
      lookup_write_strobe_q <= lookup_write_strobe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer, registered at the setup edge so the access phase sees it
  always_comb begin
    pready_d  = 1'b1;
    prdata_d  = PRDATA;
    pslverr_d = PSLVERR;
    if (setup) begin
      prdata_d  = RLA_RDATA_RST;
      pslverr_d = (sel == RLA_SEL_NONE);
      if (!PWRITE) begin
        unique case (sel)
          RLA_SEL_ADDR:   prdata_d[7:0] = {lookup_auto_step_q, lookup_address_q};
          RLA_SEL_DATA:   prdata_d[7:0] = lookup_data_value_q;
          RLA_SEL_STROBE: prdata_d[1:0] = {lookup_read_strobe_q, lookup_write_strobe_q};
          RLA_SEL_NONE:   prdata_d      = RLA_RDATA_RST;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PRDATA  <= RLA_RDATA_RST;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= pready_d;
      PRDATA  <= prdata_d;
      PSLVERR <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  addr_width_a : assert property (@(posedge CLK) disable iff (!RST_B)
    ram_req.rd |-> ram_req.addr == $past(lookup_address_q))
    else $error("RAM address differs from address register");

  data_width_a : assert property (@(posedge CLK) disable iff (!RST_B)
    ram_req.wr |-> ram_req.wdata == lookup_data_value_q)
    else $error("RAM write data differs from data register");

  strobe_start_a : assert property (@(posedge CLK) disable iff (!RST_B)
    (state_q == RLA_IDLE && (lookup_read_strobe_q || lookup_write_strobe_q)) |=> state_q == RLA_RUN ##1 done)
    else $error("Strobe did not start an access");

  strobe_hold_a : assert property (@(posedge CLK) disable iff (!RST_B)
    (state_q == RLA_RUN && op_wr_q) |-> lookup_write_strobe_q ##1 (lookup_write_strobe_q ##1 !lookup_write_strobe_q
      or (wr_acc && sel == RLA_SEL_STROBE)))
    else $error("Write strobe not held then cleared");

  auto_step_a : assert property (@(posedge CLK) disable iff (!RST_B)
    (done && lookup_auto_step_q) |=> lookup_address_q == 7'($past(lookup_address_q) + 7'h01))
    else $error("Address not stepped on completion");

  step_read_a : assert property (@(posedge CLK) disable iff (!RST_B)
    (setup && !PWRITE && sel == RLA_SEL_ADDR) |=> PRDATA[6:0] == $past(lookup_address_q))
    else $error("Address readback wrong");

  read_load_a : assert property (@(posedge CLK) disable iff (!RST_B)
    (done && !op_wr_q) |=> lookup_data_value_q == $past(ram_rdata))
    else $error("Read data not loaded");

  fixed_regs_a : assert property (@(posedge CLK) disable iff (!RST_B)
    busy && !done |=> $stable(lookup_data_value_q))
    else $error("Data register moved during access");

endmodule : rla_access

// file: test_rla_access.sv
// Self-checking testbench for the lookup RAM access register bank
`timescale 1ns/1ps
module test_rla_access;
  import rla_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus signals, all driven from time zero
  logic        CLK     = 1'b0;
  logic        RST_B   = 1'b0;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [15:0] PADDR   = 16'h0000;
  logic [31:0] PWDATA  = 32'h0000_0000;
  logic [3:0]  PSTRB   = 4'hf;
  logic        PREADY;
  logic [31:0] PRDATA;
  logic        PSLVERR;
  int          n_errors = 0;
  int          checked  = 0;
  logic [31:0] rd;
  logic        er;

  rla_access rla_access_inst (
    .CLK     (CLK),
    .RST_B   (RST_B),
    .PSEL    (PSEL),
    .PENABLE (PENABLE),
    .PWRITE  (PWRITE),
    .PADDR   (PADDR),
    .PWDATA  (PWDATA),
    .PSTRB   (PSTRB),
    .PREADY  (PREADY),
    .PRDATA  (PRDATA),
    .PSLVERR (PSLVERR)
  );

  // 50 MHz clock
  always #10 CLK = ~CLK;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic complete_run;
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // APB master; entered just after an edge, leaves the request up so a
  // following transfer may start back-to-back without a second assignment
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rd = PRDATA;
    er = PSLVERR;
    // A slave that never answers ends the run as a failure
    if (n >= 50) begin
      n_errors++;
      complete_run();
    end
  endtask : apb

  task automatic rel;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : rel

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    rel();
  endtask : wr

  task automatic rdr(input logic [15:0] a);
    apb(1'b0, a, 32'h0);
    rel();
  endtask : rdr

  // Poll the strobes under a bound; a hang here shows as a set strobe
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rdr(RLA_BA_STROBE);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 20);
    chk("strobe_clear", {30'h0, rd[1:0]}, 32'h0);
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rdr(RLA_BA_ADDR);
    chk("addr_rst", rd, 32'h0);
    chk("addr_err", {31'h0, er}, 32'h0);
    rdr(RLA_BA_DATA);
    chk("data_rst", rd, 32'h0);
    rdr(RLA_BA_STROBE);
    chk("strobe_rst", rd, 32'h0);
  endtask : t_reset

  // Auto-step writes across the top of the RAM; address must wrap
  task automatic t_write_auto;
    wr(RLA_BA_ADDR, 32'h0000_00fe);
    for (int i = 0; i < 2; i++) begin
      wr(RLA_BA_DATA, 32'h0000_00a5 + 32'(i));
      apb(1'b1, RLA_BA_STROBE, 32'h1);
      apb(1'b1, RLA_BA_ADDR, 32'h05);
      apb(1'b0, RLA_BA_STROBE, 32'h0);
      rel();
      chk("strobe_held", rd, 32'h1);
      wait_done();
      rdr(RLA_BA_ADDR);
      chk("addr_step", rd, {24'h0, 1'b1, 7'(7'h7e + i + 1)});
    end
  endtask : t_write_auto

  // Reads without auto-step, then a write with no byte lane enabled
  task automatic t_read;
    for (int i = 0; i < 2; i++) begin
      wr(RLA_BA_ADDR, 32'h7e + 32'(i));
      wr(RLA_BA_STROBE, 32'h2);
      wait_done();
      rdr(RLA_BA_DATA);
      chk("read_byte", rd, 32'ha5 + 32'(i));
      rdr(RLA_BA_ADDR);
      chk("addr_kept", rd, 32'h7e + 32'(i));
    end
    PSTRB <= 4'h0;
    wr(RLA_BA_DATA, 32'h11);
    PSTRB <= 4'hf;
    rdr(RLA_BA_DATA);
    chk("no_lane", rd, 32'ha6);
  endtask : t_read

  // Both strobes at once: write runs first, then read at the stepped address
  task automatic t_both;
    wr(RLA_BA_ADDR, 32'h0000_00fd);
    wr(RLA_BA_DATA, 32'h0000_005a);
    wr(RLA_BA_STROBE, 32'h3);
    wait_done();
    rdr(RLA_BA_DATA);
    chk("both_read", rd, 32'ha5);
    rdr(RLA_BA_ADDR);
    chk("both_step", rd, 32'hff);
    wr(RLA_BA_ADDR, 32'h0000_007d);
    wr(RLA_BA_STROBE, 32'h2);
    wait_done();
    rdr(RLA_BA_DATA);
    chk("both_write", rd, 32'h5a);
  endtask : t_both

  // Reset pulled in mid-run must bring every register back to zero
  task automatic t_mid_reset;
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge CLK);
    t_reset();
  endtask : t_mid_reset

  // Upper strobe bits and unmapped places must do nothing
  task automatic t_odd;
    wr(RLA_BA_STROBE, 32'hfc);
    rdr(RLA_BA_STROBE);
    chk("strobe_hi", rd, 32'h0);
    wr(RLA_BA_STROBE + 16'h4, 32'hff);
    chk("unmap_werr", {31'h0, er}, 32'h1);
    rdr(RLA_BA_STROBE + 16'h4);
    chk("unmap_rerr", {31'h0, er}, 32'h1);
    chk("unmap_data", rd, 32'h0);
  endtask : t_odd

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for four cycles, settle, then run
  initial begin
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge CLK);
    t_reset();
    t_write_auto();
    t_read();
    t_both();
    t_mid_reset();
    t_odd();
    complete_run();
  end

  // Watchdog; the whole run needs under two hundred cycles
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end

endmodule : test_rla_access
